// file: hw/fsp_pkg.sv
// Types for the self-programming page sequencer
package fsp_pkg;
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_ARMED,
        FSP_WRITE,
        FSP_CAL
    } fsp_state_e;

    typedef struct packed {
        logic [7:0] pointer_high_byte;
        logic [7:0] pointer_low_byte;
    } fsp_pointer_s;

    typedef struct packed {
        logic write;
        logic [7:0] data;
    } fsp_ctl_wr_s;
endpackage

// file: hw/fsp_regs.svh
// Constants for the self-programming page sequencer
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_CMD_PAGE_WRITE 8'h05
`define FSP_SPM_WINDOW 4'h4
`define FSP_WRITE_TIME_NS 32'd4500000
`define FSP_CLK_NS 32'd20
`define FSP_WRITE_CYCLES (`FSP_WRITE_TIME_NS / `FSP_CLK_NS)
`define FSP_CAL_ADDR 16'h0000
`define FSP_TRIM_RESET 8'h00
`define FSP_FLASH_WORD_BITS 6
`define FSP_FLASH_PC_MSB 12
`define FSP_EE_BYTE_BITS 2
`define FSP_EE_MSB 8
`endif

// file: hw/fsp_sequencer.sv
// Self-programming page write sequencer with Flash and EEPROM paging
//****************************************************************
// Summary of operation
// - The data word pair is ignored during a page write.
// - The core is stalled for the whole page write.
// - The Flash address is bits 12 to 0 of the 16-bit pointer, high byte giving bits 15 to 8.
// - Low pointer bits pick the word in a page, upper bits pick the page.
// - The load instruction addresses bytes, bit 0 picking low or high byte.
// - Reset clears the oscillator trim; the calibration byte is copied into it in the first cycle after reset.
// - Pages are 32 words (PC[4:0]) or 64 words (PC[5:0]) on the largest part.
// - EEPROM pages are 4 bytes, bits 1:0 the byte, bits above the page.
//****************************************************************
`include "fsp_regs.svh"

module fsp_sequencer #(
    parameter int WORD_BITS = `FSP_FLASH_WORD_BITS,
    parameter int PC_MSB = `FSP_FLASH_PC_MSB,
    parameter int EE_MSB = `FSP_EE_MSB,
    parameter int WRITE_CYCLES = `FSP_WRITE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire fsp_pkg::fsp_ctl_wr_s ctl_wr,
    input wire logic store_program_memory_instr,
    input wire logic load_program_memory_instr,
    input wire fsp_pkg::fsp_pointer_s pointer,
    input wire logic [15:0] write_word,
    input wire logic [EE_MSB:0] eeprom_byte_address,
    input wire logic [15:0] flash_rdata,
    input wire logic [7:0] cal_rdata,
    output logic core_stall,
    output logic flash_page_write,
    output logic [PC_MSB-WORD_BITS:0] flash_page,
    output logic [WORD_BITS-1:0] flash_word,
    output logic [7:0] lpm_data,
    output logic lpm_valid,
    output logic [7:0] selfprog_control_status,
    output logic [7:0] rc_oscillator_trim,
    output logic cal_read,
    output logic [16:0] cal_addr,
    output logic [EE_MSB-`FSP_EE_BYTE_BITS:0] eeprom_page,
    output logic [`FSP_EE_BYTE_BITS-1:0] eeprom_byte
);
    //************************************************************
    // Local sizes and state
    //************************************************************
    localparam int CW = $clog2(WRITE_CYCLES + 1);
    localparam int PAGE_BITS = PC_MSB - WORD_BITS + 1;
    localparam int EE_BITS = `FSP_EE_BYTE_BITS;
    localparam int EE_PAGE_BITS = EE_MSB - EE_BITS + 1;

    fsp_pkg::fsp_state_e state;
    fsp_pkg::fsp_state_e next_state;
    logic [3:0] window;
    logic [3:0] next_window;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;

    //************************************************************
    // Helpers
    //************************************************************
    // Byte lane of a program word chosen by the pointer bit 0
    function automatic logic [7:0] byte_lane(input logic [15:0] word,
        input logic high);
        byte_lane = high ? word[15:8] : word[7:0];
    endfunction

    // Window counter steps down to zero and rests there
    function automatic logic [3:0] step_down(input logic [3:0] value);
        step_down = value != 4'h0 ? value - 4'h1 : 4'h0;
    endfunction

    //************************************************************
    // Address split
    //************************************************************
    wire [15:0] z_word = {pointer.pointer_high_byte,
                          pointer.pointer_low_byte};
    wire [PC_MSB:0] pc_addr = z_word[PC_MSB:0];
    wire [PAGE_BITS-1:0] pc_page =
        pc_addr[PC_MSB:WORD_BITS];
    wire [WORD_BITS-1:0] pc_word =
        pc_addr[WORD_BITS-1:0];
    wire byte_high = z_word[0];
    wire [7:0] lpm_byte = byte_lane(flash_rdata, byte_high);
    wire [EE_PAGE_BITS-1:0] ee_page =
        eeprom_byte_address[EE_MSB:EE_BITS];
    wire [EE_BITS-1:0] ee_byte =
        eeprom_byte_address[EE_BITS-1:0];
    // Data pair has no path into a page write
    wire unused_ok = ^write_word;

    //************************************************************
    // Command decode
    //************************************************************
    // No new command is taken while a write runs
    wire cmd_open = state == fsp_pkg::FSP_IDLE
        || state == fsp_pkg::FSP_ARMED;
    wire cmd_ok = ctl_wr.data == `FSP_CMD_PAGE_WRITE;
    wire arm = ctl_wr.write && cmd_ok && cmd_open;
    wire window_open = window != 4'h0;
    wire spm_go = state == fsp_pkg::FSP_ARMED
        && store_program_memory_instr && window_open;
    wire in_write = state == fsp_pkg::FSP_WRITE;
    wire write_done = in_write
        && count == CW'(WRITE_CYCLES - 1);
    wire window_lapse = state == fsp_pkg::FSP_ARMED
        && !window_open && !arm;
    wire load_take = load_program_memory_instr && !core_stall;
    wire in_cal = state == fsp_pkg::FSP_CAL;

    assign next_window = arm ? `FSP_SPM_WINDOW
        : step_down(window);
    assign next_count = in_write && !write_done
        ? count + CW'(1) : '0;

    //************************************************************
    // State machine
    //************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            fsp_pkg::FSP_CAL: begin
                next_state = fsp_pkg::FSP_IDLE;
            end
            fsp_pkg::FSP_IDLE: begin
                if (arm)
                    next_state = fsp_pkg::FSP_ARMED;
            end
            fsp_pkg::FSP_ARMED: begin
                if (spm_go)
                    next_state = fsp_pkg::FSP_WRITE;
                else if (window_lapse)
                    next_state = fsp_pkg::FSP_IDLE;
            end
            fsp_pkg::FSP_WRITE: begin
                if (write_done)
                    next_state = fsp_pkg::FSP_IDLE;
            end
        endcase
    end

    //************************************************************
    // Sequencer registers
    //************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fsp_pkg::FSP_CAL;
            window <= 4'h0;
            count <= '0;
        end else begin
            state <= next_state;
            window <= next_window;
            count <= next_count;
        end
    end

    // Stall follows the write state, released as the write ends
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_stall <= 1'b0;
            flash_page_write <= 1'b0;
        end else begin
            core_stall <= next_state == fsp_pkg::FSP_WRITE;
            flash_page_write <= spm_go;
        end
    end

    // Page and word captured at the store
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_page <= '0;
            flash_word <= '0;
        end else if (spm_go) begin
            flash_page <= pc_page;
            flash_word <= pc_word;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            selfprog_control_status <= 8'h00;
        end else if (arm) begin
            selfprog_control_status <= ctl_wr.data;
        end else if (write_done || window_lapse) begin
            selfprog_control_status <= 8'h00;
        end
    end

    //************************************************************
    // Byte reads
    //************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lpm_data <= 8'h00;
            lpm_valid <= 1'b0;
        end else begin
            lpm_valid <= load_take;
            if (load_take)
                lpm_data <= lpm_byte;
        end
    end

    //************************************************************
    // Calibration load
    //************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_oscillator_trim <= `FSP_TRIM_RESET;
            cal_read <= 1'b0;
            cal_addr <= 17'h0_0000;
        end else begin
            cal_read <= in_cal;
            cal_addr <= {1'b1, `FSP_CAL_ADDR};
            if (in_cal)
                rc_oscillator_trim <= cal_rdata;
        end
    end

    //************************************************************
    // EEPROM paging
    //************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eeprom_page <= '0;
            eeprom_byte <= '0;
        end else begin
            eeprom_page <= ee_page;
            eeprom_byte <= ee_byte;
        end
    end
endmodule

// file: tb/fsp_checker.sv
// Port assertions for the sequencer
`include "fsp_regs.svh"

module fsp_checker #(
    parameter int WRITE_CYCLES = `FSP_WRITE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire fsp_pkg::fsp_ctl_wr_s ctl_wr,
    input wire logic load_program_memory_instr,
    input wire fsp_pkg::fsp_pointer_s pointer,
    input wire logic [15:0] flash_rdata,
    input wire logic [7:0] cal_rdata,
    input wire logic core_stall,
    input wire logic flash_page_write,
    input wire logic [7:0] lpm_data,
    input wire logic lpm_valid,
    input wire logic [7:0] selfprog_control_status,
    input wire logic [7:0] rc_oscillator_trim,
    input wire logic cal_read
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    int stall_len;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            stall_len <= 0;
        else
            stall_len <= core_stall ? stall_len + 1 : 0;
    end
    chk_write_stall: assert property (
        flash_page_write |-> core_stall) else $error("no stall");
    chk_stall_cause: assert property (
        $rose(core_stall) |-> flash_page_write) else $error("stray stall");
    chk_stall_ends: assert property (
        stall_len <= WRITE_CYCLES) else $error("stuck");
    chk_stall_length: assert property (
        $fell(core_stall) |-> stall_len == WRITE_CYCLES)
        else $error("stall length");
    chk_no_rewrite: assert property (
        core_stall && $past(core_stall) |-> !flash_page_write)
        else $error("rewrite");
    chk_lpm_answer: assert property (
        load_program_memory_instr && !core_stall |=> lpm_valid)
        else $error("no load");
    chk_lpm_byte: assert property (
        lpm_valid |-> lpm_data == ($past(pointer.pointer_low_byte[0]) ?
        $past(flash_rdata[15:8]) : $past(flash_rdata[7:0])))
        else $error("byte");
    chk_arm_status: assert property (
        ctl_wr.write && ctl_wr.data == 8'h05 && !core_stall
        |=> selfprog_control_status == 8'h05) else $error("arm");
    chk_cal_trim: assert property (
        cal_read |-> rc_oscillator_trim == $past(cal_rdata))
        else $error("trim");
endmodule
bind fsp_sequencer fsp_checker #(.WRITE_CYCLES(WRITE_CYCLES))
    i_chk (.sys_clk, .rst_n, .ctl_wr,
    .load_program_memory_instr, .pointer, .flash_rdata, .cal_rdata,
    .core_stall, .flash_page_write, .lpm_data, .lpm_valid,
    .selfprog_control_status, .rc_oscillator_trim, .cal_read);

// file: tb/fsp_core_model.sv
// Core model issuing the self-programming command and store
module fsp_core_model (
    input wire logic sys_clk,
    output fsp_pkg::fsp_ctl_wr_s ctl_wr,
    output logic store_program_memory_instr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ctl_wr = '0;
    initial store_program_memory_instr = 1'b0;
    // Command write, then the store gap cycles later
    task automatic page_write(input logic [7:0] cmd, input int gap);
        @(negedge sys_clk) ctl_wr <= '{1'b1, cmd};
        @(negedge sys_clk) ctl_wr <= '0;
        repeat (gap - 1) @(negedge sys_clk);
        store_program_memory_instr <= 1'b1;
        @(negedge sys_clk) store_program_memory_instr <= 1'b0;
    endtask
endmodule

// file: tb/tb_top.sv
// Bench for the self-programming sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WC = 20;
    logic sys_clk = 0, rst_n = 0, core_stall, flash_page_write, lpm_valid;
    logic store_program_memory_instr, load_program_memory_instr = 0, cal_read;
    fsp_pkg::fsp_ctl_wr_s ctl_wr;
    fsp_pkg::fsp_pointer_s pointer = '0;
    logic [15:0] write_word = 16'hffff, flash_rdata = '0;
    logic [8:0] eeprom_byte_address = '0;
    logic [7:0] cal_rdata, lpm_data, selfprog_control_status;
    logic [7:0] rc_oscillator_trim, e8;
    logic [6:0] flash_page, eeprom_page;
    logic [5:0] flash_word;
    logic [1:0] eeprom_byte;
    logic [16:0] cal_addr;
    int failures = 0, tests_run = 0, n;
    logic [48:0] rows [3] = '{{16'h0000, 16'h1234, 9'h000, 8'h34},
        {16'h1fff, 16'ha55a, 9'h1ff, 8'ha5}, {16'h0a41, 16'h00ff, 9'h106, 8'h00}};
    always #10 sys_clk = ~sys_clk;
    fsp_sequencer #(.WRITE_CYCLES(WC)) i_dut (.sys_clk, .rst_n, .ctl_wr,
        .store_program_memory_instr, .load_program_memory_instr, .pointer,
        .write_word, .eeprom_byte_address, .flash_rdata, .cal_rdata,
        .core_stall, .flash_page_write, .flash_page, .flash_word, .lpm_data,
        .lpm_valid, .selfprog_control_status, .rc_oscillator_trim, .cal_read,
        .cal_addr, .eeprom_page, .eeprom_byte);
    fsp_core_model i_core (.sys_clk, .ctl_wr, .store_program_memory_instr);
    task automatic chk(input logic [16:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset(input logic [7:0] c);
        cal_rdata = c;
        rst_n = 0;
        repeat (6) @(negedge sys_clk);
        rst_n = 1;
        @(negedge sys_clk);
        chk(rc_oscillator_trim, c);
        chk(cal_addr, 17'h1_0000);
        chk(cal_read, 1'b1);
        @(negedge sys_clk);
        chk(cal_read, 1'b0);
    endtask
    task automatic pw_run(input logic [7:0] cmd, input int gap, len);
        n = 0;
        i_core.page_write(cmd, gap);
        chk(flash_page_write, len > 0);
        while (core_stall && n < 99) begin
            n++;
            @(negedge sys_clk);
        end
        chk(n[16:0], len[16:0]);
        chk(selfprog_control_status, 0);
    endtask
    initial begin
        do_reset(8'h5a);
        foreach (rows[i]) begin
            {pointer, flash_rdata, eeprom_byte_address, e8} = rows[i];
            load_program_memory_instr = 1;
            @(negedge sys_clk) load_program_memory_instr = 0;
            chk(lpm_data, e8);
            chk(lpm_valid, 1'b1);
            chk({eeprom_page, eeprom_byte}, eeprom_byte_address);
        end
        pointer = 16'h1fc0;
        pw_run(8'h05, 1, WC);
        chk({flash_page, flash_word}, 13'h1fc0);
        pointer = 16'h0040;
        write_word = 16'h0000;
        pw_run(8'h05, 4, WC);
        chk(flash_page, 7'h01);
        pw_run(8'h05, 2, WC);
        chk(flash_page, 7'h01);
        pw_run(8'h05, 5, 0);
        pw_run(8'h03, 1, 0);
        do_reset(8'h3c);
        test_done;
    end
endmodule
